// ---- shared/cfg_load_pkg.sv ----
// Constants and types shared by the configuration loader
package cfg_load_pkg;
	localparam int CFG_BITS = 160;
	localparam int NUM_OUTPUTS = 9;
	localparam int CLK_MHZ = 50;
	localparam int SETTLE_MS = 10;
	localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;
	localparam logic [CFG_BITS-1:0] CFG_RESET = {CFG_BITS{1'b0}};
	typedef enum logic [1:0] {OUT_REFERENCE, OUT_SETTLING, OUT_PROGRAMMED} out_mode_e;
endpackage

// ---- design/pin_sync.sv ----
// Two-flop synchroniser for a group of pins
module pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule

// ---- design/serial_config_load_port.sv ----
// Three-wire configuration loader with transparent latch and output gating
// Contract
// - Each shift clock pulse moves the serial data line into the shift register by one bit.
// - After 160 bits the host raises the strobe and the shift register is copied into the latch.
// - Outputs carry the new frequencies no sooner than 10 ms after the latch changes.
// - The latch is transparent while the strobe is high, so shifts then reach CONFIG_WORD at once.
// - A low power-down input clears POWERED_UP and tri-states all output clocks; loading goes on.
// - Until a word is loaded, all nine outputs carry the reference clock while power-down is high.
// - Programmed frequencies appear only after the strobe and the settling wait, while power-down is high.
module serial_config_load_port
	import cfg_load_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// Programming pins
	input wire logic SHIFT_CLK,
	input wire logic SERIAL_DATA,
	input wire logic STROBE,
	input wire logic POWER_DOWN_TRISTATE_N,
	// Shared reference clock and synthesised clock sources, one per output
	input wire logic REF_IN,
	input wire logic [cfg_load_pkg::NUM_OUTPUTS-1:0] SYNTH_CLK,
	// Output clocks
	output logic [cfg_load_pkg::NUM_OUTPUTS-1:0] CLK_OUT,
	output logic [cfg_load_pkg::NUM_OUTPUTS-1:0] CLK_OUT_OE,
	// Configuration to the synthesiser
	output logic [cfg_load_pkg::CFG_BITS-1:0] CONFIG_WORD,
	output logic CONFIG_VALID,
	output logic POWERED_UP
);
	import cfg_load_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// A zero wait would let new settings reach the outputs unsettled
	if (SETTLE_COUNT < 1) begin : g_settle_check
		$error("SETTLE_COUNT must be at least one");
	end

	localparam int CNT_W = $clog2(SETTLE_COUNT + 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_COUNT);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [3:0] pins_sync;
	logic sclk_s, sdata_s, strobe_s, pd_n_s;

	// Shift clock high and low phases need more than one REF_CLK cycle each to be seen
	pin_sync #(.WIDTH(4)) u_sync (
		.clk(REF_CLK),
		.rst(RESET),
		.din({SHIFT_CLK, SERIAL_DATA, STROBE, POWER_DOWN_TRISTATE_N}),
		.dout(pins_sync)
	);

	assign {sclk_s, sdata_s, strobe_s, pd_n_s} = pins_sync;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sclk_prev;
		logic [CFG_BITS-1:0] shift;
		logic shift_seen;
		logic [CFG_BITS-1:0] latch;
		logic loaded;
		out_mode_e mode;
		logic [CNT_W-1:0] settle;
		logic [NUM_OUTPUTS-1:0] clk_out;
		logic [NUM_OUTPUTS-1:0] clk_oe;
		logic powered;
	} state_s;

	state_s st_reg, st_next;
	logic sclk_rise;
	logic restart;
	logic [CFG_BITS-1:0] shifted;

	always_comb begin
		st_next = st_reg;
		restart = 1'b0;
		sclk_rise = sclk_s && !st_reg.sclk_prev;
		shifted = {st_reg.shift[CFG_BITS-2:0], sdata_s};
		st_next.sclk_prev = sclk_s;
		st_next.powered = pd_n_s;
		if (sclk_rise) begin
			st_next.shift = shifted;
			st_next.shift_seen = 1'b1;
		end
		// Transparent latch: follows the shift register while strobe is high
		if (strobe_s) begin
			st_next.latch = sclk_rise ? shifted : st_reg.shift;
			// A strobe held by its pull-up with nothing shifted keeps the reference outputs
			if (st_next.shift_seen && (st_next.latch != st_reg.latch || !st_reg.loaded)) begin
				restart = 1'b1;
				st_next.loaded = 1'b1;
				st_next.mode = OUT_SETTLING;
				st_next.settle = CNT_LOAD;
			end
		end
		case (st_reg.mode)
			OUT_REFERENCE: ;
			OUT_SETTLING: begin
				// Transparency re-arms the wait on every change; settling ends at zero
				if (!restart) begin
					if (st_reg.settle != CNT_ZERO)
						st_next.settle = st_reg.settle - 1'b1;
					else
						st_next.mode = OUT_PROGRAMMED;
				end
			end
			OUT_PROGRAMMED: ;
			default: st_next.mode = OUT_REFERENCE;
		endcase
		// Reference clock until programmed frequencies have settled
		// Forwarded clocks are resampled on REF_CLK, so their edges land on its grid
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			st_next.clk_out[i] = (st_reg.mode == OUT_PROGRAMMED) ? SYNTH_CLK[i] : REF_IN;
		end
		// Power-down wins over every mode and stops outputs
		if (!pd_n_s) begin
			st_next.clk_out = '0;
			st_next.clk_oe = '0;
		end else begin
			st_next.clk_oe = '1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			st_reg <= '{sclk_prev: 1'b0, shift: CFG_RESET, shift_seen: 1'b0, latch: CFG_RESET, loaded: 1'b0,
				mode: OUT_REFERENCE, settle: CNT_ZERO, clk_out: '0, clk_oe: '0, powered: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign CLK_OUT = st_reg.clk_out;
	assign CLK_OUT_OE = st_reg.clk_oe;
	assign CONFIG_WORD = st_reg.latch;
	assign CONFIG_VALID = st_reg.loaded;
	assign POWERED_UP = st_reg.powered;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_rise;
		sclk_s && !st_reg.sclk_prev;
	endsequence

	sequence s_settle_end;
		st_reg.mode == OUT_SETTLING && st_reg.settle == CNT_ZERO && !strobe_s;
	endsequence

	a_shift_advance: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_rise |=> st_reg.shift[0] == $past(sdata_s) && st_reg.shift[CFG_BITS-1:1] == $past(st_reg.shift[CFG_BITS-2:0]))
		else $error("shift register did not advance");

	a_shift_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
		!(sclk_s && !st_reg.sclk_prev) |=> $stable(st_reg.shift))
		else $error("shift register moved without a rising shift clock");

	a_strobe_copy: assert property (@(posedge REF_CLK) disable iff (RESET)
		strobe_s && !(sclk_s && !st_reg.sclk_prev) |=> st_reg.latch == $past(st_reg.shift))
		else $error("latch did not copy shift register");

	a_latch_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
		!strobe_s |=> $stable(st_reg.latch))
		else $error("latch changed with strobe low");

	a_transparent: assert property (@(posedge REF_CLK) disable iff (RESET)
		strobe_s ##0 s_rise |=> st_reg.latch == st_reg.shift)
		else $error("latch not transparent during shift");

	a_pd_tristate: assert property (@(posedge REF_CLK) disable iff (RESET)
		!pd_n_s |=> CLK_OUT_OE == '0 && CLK_OUT == '0)
		else $error("outputs driven during power-down");

	a_ref_default: assert property (@(posedge REF_CLK) disable iff (RESET)
		pd_n_s && !st_reg.loaded |=> CLK_OUT == {NUM_OUTPUTS{$past(REF_IN)}})
		else $error("unloaded outputs not on reference");

	a_settle_bound: assert property (@(posedge REF_CLK) disable iff (RESET)
		st_reg.mode == OUT_SETTLING && !strobe_s && st_reg.settle != CNT_ZERO
		|=> st_reg.settle == $past(st_reg.settle) - 1'b1)
		else $error("settle count did not step down");

	a_settle_done: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_settle_end |=> st_reg.mode == OUT_PROGRAMMED)
		else $error("settling did not end at zero");

	a_prog_outputs: assert property (@(posedge REF_CLK) disable iff (RESET)
		pd_n_s && st_reg.mode == OUT_PROGRAMMED |=> CLK_OUT == $past(SYNTH_CLK))
		else $error("programmed outputs not on synthesised clocks");

	a_unloaded_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
		!st_reg.loaded && !st_reg.shift_seen && !(sclk_s && !st_reg.sclk_prev) |=> !st_reg.loaded)
		else $error("loaded without any shifted bit");

	a_valid_on_strobe: assert property (@(posedge REF_CLK) disable iff (RESET)
		strobe_s && st_reg.shift_seen |=> CONFIG_VALID)
		else $error("strobe after shifting did not mark the word loaded");

	a_oe_on: assert property (@(posedge REF_CLK) disable iff (RESET)
		pd_n_s |=> CLK_OUT_OE == '1)
		else $error("outputs not enabled while powered");

	a_pd_release: assert property (@(posedge REF_CLK) disable iff (RESET)
		$rose(pd_n_s) |=> CLK_OUT_OE == '1)
		else $error("outputs not enabled after power-down release");
endmodule

// ---- verif/cfg_host.sv ----
// Host model that shifts a word into the programming port and strobes it
module cfg_host
	import cfg_load_pkg::*;
(
	// Clock
	input wire logic clk,
	// Programming pins
	output logic sclk = 1'b0,
	output logic sdata = 1'b0,
	output logic strobe = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Eight cycles per bit make the 160 ns link period; the clock stands low between words
	task automatic shift_word(input logic [CFG_BITS-1:0] w, input logic hold);
		@(posedge clk);
		strobe <= hold;
		for (int i = CFG_BITS - 1; i >= 0; i--) begin
			@(posedge clk);
			sdata <= w[i];
			repeat (3) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		@(posedge clk);
		sdata <= ~sdata;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
	endtask
	task automatic pulse_strobe();
		@(posedge clk);
		strobe <= 1'b1;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
	endtask
endmodule

// ---- verif/test_serial_config_load_port.sv ----
// Testbench for the serial configuration loader
module test_serial_config_load_port;
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_load_pkg::*;
	typedef struct {logic [CFG_BITS-1:0] w; logic pd_n;} row_s;
	logic ref_clk = 1'b0, reset = 1'b1, pd_n = 1'b1, ref_in = 1'b0;
	logic [NUM_OUTPUTS-1:0] synth = 9'h0AA, clk_out, clk_out_oe;
	logic sclk, sdata, strobe, config_valid, powered_up;
	logic [CFG_BITS-1:0] config_word;
	int checks = 0, n_mismatch = 0, cyc = 0;
	row_s rows [3] = '{'{{5{32'h8000_0001}}, 1'b1}, '{{5{32'h1234_5678}}, 1'b0}, '{{5{32'hFFFF_0000}}, 1'b1}};
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		ref_in <= ~ref_in;
		synth <= ~synth;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	serial_config_load_port #(.SETTLE_COUNT(20)) serial_config_load_port_inst (.REF_CLK(ref_clk), .RESET(reset),
		.SHIFT_CLK(sclk), .SERIAL_DATA(sdata), .STROBE(strobe), .POWER_DOWN_TRISTATE_N(pd_n), .REF_IN(ref_in),
		.SYNTH_CLK(synth), .CLK_OUT(clk_out), .CLK_OUT_OE(clk_out_oe), .CONFIG_WORD(config_word),
		.CONFIG_VALID(config_valid), .POWERED_UP(powered_up));
	cfg_host cfg_host_inst (.clk(ref_clk), .sclk(sclk), .sdata(sdata), .strobe(strobe));
	task automatic chk(input string nm, input logic [CFG_BITS-1:0] exp, input logic [CFG_BITS-1:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	// Registered outputs lag one cycle, and both sources toggle every cycle
	task automatic out_chk(input logic pd, input logic prog);
		logic [NUM_OUTPUTS-1:0] exp;
		@(negedge ref_clk);
		exp = !pd ? '0 : prog ? ~synth : {NUM_OUTPUTS{~ref_in}};
		chk("clk_out", exp, clk_out);
		chk("clk_out_oe", pd ? 9'h1FF : 9'h000, clk_out_oe);
		chk("powered_up", pd, powered_up);
		chk("config_valid", prog, config_valid);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (5) @(posedge ref_clk);
		out_chk(1'b1, 1'b0);
		chk("config_valid", 1'b0, config_valid);
		// A strobe with nothing shifted, as from the pull-up at start, must keep the reference
		cfg_host_inst.pulse_strobe();
		repeat (30) @(negedge ref_clk);
		out_chk(1'b1, 1'b0);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			pd_n <= rows[i].pd_n;
			cfg_host_inst.shift_word(rows[i].w, 1'b0);
			cfg_host_inst.pulse_strobe();
			repeat (40) @(negedge ref_clk);
			chk("config_word", rows[i].w, config_word);
			out_chk(rows[i].pd_n, 1'b1);
		end
		// Shifting with the strobe held high must reach the latch directly
		cfg_host_inst.shift_word({10{16'hC3A5}}, 1'b1);
		repeat (5) @(negedge ref_clk);
		chk("config_word", {10{16'hC3A5}}, config_word);
		// A word shifted with the strobe low must leave the latch alone
		cfg_host_inst.shift_word(rows[0].w, 1'b0);
		repeat (5) @(negedge ref_clk);
		chk("config_word", {10{16'hC3A5}}, config_word);
		@(posedge ref_clk);
		reset <= 1'b1;
		@(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		chk("clk_out_oe", 9'h000, clk_out_oe);
		chk("config_valid", 1'b0, config_valid);
		chk("config_word", CFG_RESET, config_word);
		tally_and_finish();
	end
endmodule
